/* File: rsc_pkg.sv */
package rsc_pkg;

   // ------------------------------------------------------------------
   // Link bit positions within every two-bit link vector
   // ------------------------------------------------------------------
   localparam int UL_IDX = 0;
   localparam int DL_IDX = 1;

   typedef logic [1:0] rsc_link_type;

   localparam rsc_link_type RSC_LINKS_NONE = 2'h0;
   localparam rsc_link_type RSC_LINKS_UL   = 2'h1;
   localparam rsc_link_type RSC_LINKS_DL   = 2'h2;
   localparam rsc_link_type RSC_LINKS_BOTH = 2'h3;

   // ------------------------------------------------------------------
   // Backup modes
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      RSC_MODE_MANUAL  = 3'h1,
      RSC_MODE_PAIRED  = 3'h2,
      RSC_MODE_PERLINK = 3'h4
   } rsc_mode_type;

   typedef struct packed {
      logic         redundancy_enable;
      rsc_mode_type backup_mode_select;
   } rsc_cfg_type;

   typedef struct packed {
      logic         redundancy_enable;
      rsc_mode_type backup_mode_select;
      logic         interconnect_missing;
      logic         online;
      rsc_link_type held;
      rsc_link_type peer_fault;
   } rsc_status_type;

   typedef struct packed {
      rsc_cfg_type    cfg;
      rsc_link_type   held;
      logic           missing;
      logic           cfg_rejected;
      rsc_status_type status;
   } rsc_state_type;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic         RSC_EN_RESET   = 1'b0;
   localparam rsc_mode_type RSC_MODE_RESET = RSC_MODE_MANUAL;
   localparam rsc_link_type RSC_HELD_RESET = RSC_LINKS_BOTH;

endpackage : rsc_pkg

/* File: rsc_switchover.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - Peer-based switchover happens only while redundancy enable is set.
// - With redundancy enabled and the cable present, local and peer faults drive online decisions in paired and per-link modes.
// - A missing interconnect raises the cable-missing indication.
// - Configuration writes are refused while the interconnect is missing.
// - Mode resets to manual; manual switch command goes online only while the cable is present.
// - Paired mode: offline unit with no local fault goes online when the peer reports a fault and holds no link.
// - Paired mode: a fault on either link releases both links.
// - Per-link mode: only the faulted link is released, the other kept.
// - Backup status is refreshed every cycle and readable any time.
module rsc_switchover
   import rsc_pkg::*;
(
   input  wire logic           ref_clk,
   input  wire logic           nrst,
   input  wire logic           cfg_wr,
   input  wire rsc_cfg_type    cfg_in,
   input  wire logic           switch_cmd,
   input  wire logic           cable_present,
   input  wire rsc_link_type   local_fault,
   input  wire rsc_link_type   peer_fault,
   input  wire rsc_link_type   peer_held,
   output logic                uplink_ctrl,
   output logic                downlink_ctrl,
   output logic                online,
   output logic                interconnect_missing_indication,
   output logic                cfg_rejected,
   output rsc_status_type      backup_status_view
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   rsc_state_type q;
   rsc_state_type next_q;
   logic          mode_legal;

   assign mode_legal = cfg_in.backup_mode_select inside
      {RSC_MODE_MANUAL, RSC_MODE_PAIRED, RSC_MODE_PERLINK};

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      next_q              = q;
      next_q.cfg_rejected = 1'b0;
      next_q.missing      = !cable_present;

      // An illegal mode code is refused rather than half-applied.
      if (cfg_wr) begin
         if (!cable_present || !mode_legal) begin
            next_q.cfg_rejected = 1'b1;
         end else begin
            next_q.cfg = cfg_in;
         end
      end

      // Without redundancy the unit stands alone and owns both links.
      if (!q.cfg.redundancy_enable) begin
         next_q.held = RSC_LINKS_BOTH;
      end else if (cable_present) begin
         // Peer status is meaningless without the cable, so hold.
         unique case (q.cfg.backup_mode_select)
            RSC_MODE_MANUAL: begin
               if (switch_cmd) begin
                  next_q.held = RSC_LINKS_BOTH;
               end
            end
            RSC_MODE_PAIRED: begin
               // Any local fault drops both links, even a link that a
               // part-held unit no longer owns, so the pair stays paired.
               if (|local_fault) begin
                  next_q.held = RSC_LINKS_NONE;
               end else if (q.held == RSC_LINKS_NONE && |peer_fault &&
                            local_fault == RSC_LINKS_NONE &&
                            peer_held == RSC_LINKS_NONE) begin
                  next_q.held = RSC_LINKS_BOTH;
               end
            end
            RSC_MODE_PERLINK: begin
               // Each link is decided on its own; a link held by the
               // peer is never taken, which keeps ownership exclusive.
               next_q.held = (q.held & ~local_fault) |
                             (~q.held & peer_fault & ~local_fault &
                              ~peer_held);
            end
         endcase
      end

      next_q.status.redundancy_enable    = next_q.cfg.redundancy_enable;
      next_q.status.backup_mode_select   = next_q.cfg.backup_mode_select;
      next_q.status.interconnect_missing = next_q.missing;
      next_q.status.online               = |next_q.held;
      next_q.status.held                 = next_q.held;
      next_q.status.peer_fault           = peer_fault;
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         q.cfg.redundancy_enable  <= RSC_EN_RESET;
         q.cfg.backup_mode_select <= RSC_MODE_RESET;
         q.held                   <= RSC_HELD_RESET;
         q.missing                <= 1'b0;
         q.cfg_rejected           <= 1'b0;
         q.status.redundancy_enable    <= RSC_EN_RESET;
         q.status.backup_mode_select   <= RSC_MODE_RESET;
         q.status.interconnect_missing <= 1'b0;
         q.status.online               <= |RSC_HELD_RESET;
         q.status.held                 <= RSC_HELD_RESET;
         q.status.peer_fault           <= RSC_LINKS_NONE;
      end else begin
         q <= next_q;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign uplink_ctrl                     = q.held[UL_IDX];
   assign downlink_ctrl                   = q.held[DL_IDX];
   assign online                          = q.status.online;
   assign interconnect_missing_indication = q.missing;
   assign cfg_rejected                    = q.cfg_rejected;
   assign backup_status_view              = q.status;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   logic auto_on;
   assign auto_on = q.cfg.redundancy_enable && cable_present;

   standalone_both_a: assert property (
      !q.cfg.redundancy_enable |=> uplink_ctrl && downlink_ctrl)
      else $error("standalone unit does not own both links");

   fault_moves_a: assert property (
      auto_on && q.cfg.backup_mode_select != RSC_MODE_MANUAL &&
      |(q.held & local_fault) |=> q.held != $past(q.held))
      else $error("fault on a held link changed nothing");

   cable_flag_a: assert property (
      !cable_present |=> interconnect_missing_indication ##0
      backup_status_view.interconnect_missing)
      else $error("missing cable not indicated");

   cfg_refuse_a: assert property (
      cfg_wr && !cable_present |=> cfg_rejected && $stable(q.cfg))
      else $error("configuration changed without cable");

   reset_manual_a: assert property (
      $rose(nrst) |-> q.cfg.backup_mode_select == RSC_MODE_MANUAL &&
      !q.cfg.redundancy_enable)
      else $error("mode not manual after reset");

   manual_switch_a: assert property (
      auto_on && q.cfg.backup_mode_select == RSC_MODE_MANUAL &&
      switch_cmd |=> q.held == RSC_LINKS_BOTH)
      else $error("manual switch did not go online");

   paired_take_a: assert property (
      auto_on && q.cfg.backup_mode_select == RSC_MODE_PAIRED &&
      !online && |peer_fault && local_fault == RSC_LINKS_NONE &&
      peer_held == RSC_LINKS_NONE |=> uplink_ctrl && downlink_ctrl)
      else $error("paired takeover missing");

   paired_drop_a: assert property (
      auto_on && q.cfg.backup_mode_select == RSC_MODE_PAIRED &&
      |local_fault |=> !uplink_ctrl && !downlink_ctrl)
      else $error("paired release not of both links");

   perlink_keep_a: assert property (
      auto_on && q.cfg.backup_mode_select == RSC_MODE_PERLINK &&
      q.held == RSC_LINKS_BOTH && local_fault == RSC_LINKS_UL
      |=> !uplink_ctrl && downlink_ctrl)
      else $error("per-link release touched the healthy link");

   exclusive_take_a: assert property (
      auto_on && q.cfg.backup_mode_select == RSC_MODE_PERLINK &&
      !q.held[DL_IDX] && peer_held[DL_IDX] |=> !downlink_ctrl)
      else $error("took a link the peer still holds");

   status_track_a: assert property (
      $changed(q.held) |-> backup_status_view.held == q.held &&
      online == |q.held)
      else $error("backup status lags link control");

   cable_clear_a: assert property (
      cable_present |=> !interconnect_missing_indication)
      else $error("cable-missing indication stuck");

   cfg_lands_a: assert property (
      cfg_wr && cable_present && mode_legal |=>
      q.cfg == $past(cfg_in) && !cfg_rejected)
      else $error("legal configuration write was lost");

   cable_freeze_a: assert property (
      q.cfg.redundancy_enable && !cable_present |=> $stable(q.held))
      else $error("link control moved without cable");

   paired_wait_a: assert property (
      auto_on && q.cfg.backup_mode_select == RSC_MODE_PAIRED &&
      !online && peer_held != RSC_LINKS_NONE |=> !online)
      else $error("paired takeover while the peer holds a link");

   perlink_ul_keep_a: assert property (
      auto_on && q.cfg.backup_mode_select == RSC_MODE_PERLINK &&
      q.held == RSC_LINKS_BOTH && local_fault == RSC_LINKS_DL
      |=> uplink_ctrl && !downlink_ctrl)
      else $error("per-link release touched the healthy uplink");

   exclusive_ul_a: assert property (
      auto_on && q.cfg.backup_mode_select == RSC_MODE_PERLINK &&
      !q.held[UL_IDX] && peer_held[UL_IDX] |=> !uplink_ctrl)
      else $error("took the uplink while the peer holds it");

   status_cfg_a: assert property (
      backup_status_view.redundancy_enable == q.cfg.redundancy_enable &&
      backup_status_view.backup_mode_select == q.cfg.backup_mode_select)
      else $error("backup status lags the configuration");

endmodule : rsc_switchover

/* File: rsc_peer_model.sv */
`timescale 1ns/1ps

module rsc_peer_model
   import rsc_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          nrst,
   input  wire logic          slow,
   input  wire logic          paired,
   input  wire rsc_link_type  fault_in,
   input  wire rsc_link_type  dut_held,
   output rsc_link_type       peer_fault,
   output rsc_link_type       peer_held
);
   assign peer_fault = fault_in;
   // A slow peer skips edges, so freed links may stay idle a while.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         peer_held <= RSC_LINKS_NONE;
      end else if (!slow) begin
         if (paired && fault_in != RSC_LINKS_NONE) begin
            peer_held <= RSC_LINKS_NONE;
         end else begin
            peer_held <= ~dut_held & ~fault_in;
         end
      end
   end
endmodule : rsc_peer_model

/* File: rsc_switchover_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
   failures++; $display("unexpected %s exp %h got %h", n, e, s); end end

module rsc_switchover_tb;
   import rsc_pkg::*;
   logic           ref_clk = 0, nrst = 0, cfg_wr = 0, switch_cmd = 0;
   logic           cable_present = 1, slow = 0, ul, dl, onl, miss, rej;
   rsc_cfg_type    cfg_in = 4'h1, e_cfg;
   rsc_link_type   local_fault = 2'h0, fault_in = 2'h0, e_held, p_pf;
   rsc_link_type   peer_fault, peer_held;
   rsc_status_type st;
   logic           e_miss, e_rej;
   logic [2:0]     ms [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
   int             failures = 0, checks_done = 0, cyc = 0;

   always #2 ref_clk = ~ref_clk;

   rsc_switchover u_dut (.ref_clk(ref_clk), .nrst(nrst), .cfg_wr(cfg_wr),
      .cfg_in(cfg_in), .switch_cmd(switch_cmd),
      .cable_present(cable_present), .local_fault(local_fault),
      .peer_fault(peer_fault), .peer_held(peer_held), .uplink_ctrl(ul),
      .downlink_ctrl(dl), .online(onl),
      .interconnect_missing_indication(miss), .cfg_rejected(rej),
      .backup_status_view(st));
   rsc_peer_model u_peer (.ref_clk(ref_clk), .nrst(nrst), .slow(slow),
      .paired(st.backup_mode_select == RSC_MODE_PAIRED),
      .fault_in(fault_in), .dut_held({dl, ul}), .peer_fault(peer_fault),
      .peer_held(peer_held));

   // -----------------------------------------------------------------
   // Reference model
   // -----------------------------------------------------------------
   function automatic rsc_link_type nxt(rsc_link_type h);
      rsc_link_type take;
      take = ~h & peer_fault & ~local_fault & ~peer_held;
      if (!e_cfg.redundancy_enable) return RSC_LINKS_BOTH;
      if (!cable_present) return h;
      case (e_cfg.backup_mode_select)
         RSC_MODE_MANUAL: return switch_cmd ? RSC_LINKS_BOTH : h;
         RSC_MODE_PAIRED: begin
            if (local_fault != 2'h0) return RSC_LINKS_NONE;
            if (h == 2'h0 && peer_fault != 2'h0 && peer_held == 2'h0)
               return RSC_LINKS_BOTH;
            return h;
         end
         default: return (h & ~local_fault) | take;
      endcase
   endfunction : nxt

   // Inputs are read here before the bench's non-blocking updates land.
   always @(posedge ref_clk) begin
      cyc++;
      if (!nrst) begin
         e_cfg = 4'h1;
         e_held = RSC_LINKS_BOTH;
         {e_miss, e_rej, p_pf} = 4'h0;
      end else begin
         e_held = nxt(e_held);
         e_miss = !cable_present;
         p_pf = peer_fault;
         e_rej = cfg_wr && (!cable_present || !(cfg_in.backup_mode_select
                 inside {RSC_MODE_MANUAL, RSC_MODE_PAIRED, RSC_MODE_PERLINK}));
         if (cfg_wr && !e_rej) e_cfg = cfg_in;
      end
      if (cyc == 3000) begin
         failures++;
         final_report();
      end
   end

   always @(negedge ref_clk) if (cyc > 1) begin
      `CHK("ul", e_held[UL_IDX], ul)
      `CHK("dl", e_held[DL_IDX], dl)
      `CHK("online", |e_held, onl)
      `CHK("missing", e_miss, miss)
      `CHK("rejected", e_rej, rej)
      `CHK("status", {e_cfg, e_miss, |e_held, e_held, p_pf}, st)
   end

   task automatic cfg(logic en, logic [2:0] m);
      @(posedge ref_clk);
      cfg_wr <= 1'b1;
      cfg_in <= {en, m};
      @(posedge ref_clk);
      cfg_wr <= 1'b0;
   endtask : cfg

   task automatic step(rsc_link_type lf, rsc_link_type pf, int n);
      @(posedge ref_clk);
      local_fault <= lf;
      fault_in <= pf;
      repeat (n) @(posedge ref_clk);
   endtask : step

   task automatic final_report();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : final_report

   initial begin
      void'($urandom(85));
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      cfg(1'b1, 3'h2);
      step(2'h3, 2'h0, 3);
      step(2'h0, 2'h1, 4);
      step(2'h2, 2'h0, 4);
      $display("test paired done");
      cfg(1'b1, 3'h1);
      step(2'h0, 2'h0, 3);
      switch_cmd <= 1'b1;
      @(posedge ref_clk);
      switch_cmd <= 1'b0;
      $display("test manual done");
      cfg(1'b1, 3'h4);
      step(2'h1, 2'h0, 4);
      step(2'h0, 2'h1, 5);
      $display("test per-link done");
      cable_present <= 1'b0;
      cfg(1'b1, 3'h2);
      step(2'h3, 2'h0, 3);
      cable_present <= 1'b1;
      cfg(1'b1, 3'h3);
      cfg(1'b0, 3'h2);
      step(2'h0, 2'h0, 3);
      $display("test refusals done");
      // Switch commands land in every mode; only manual mode obeys them.
      repeat (600) begin
         @(posedge ref_clk);
         switch_cmd <= ($urandom % 16) == 0;
         local_fault <= 2'($urandom);
         fault_in <= 2'($urandom);
         slow <= 1'($urandom);
         cable_present <= ($urandom % 8) != 0;
         cfg_wr <= ($urandom % 12) == 0;
         cfg_in <= {($urandom % 4) != 0, ms[$urandom % 4]};
      end
      $display("test random done");
      // A mid-run reset must bring back standalone manual operation.
      @(posedge ref_clk);
      nrst <= 1'b0;
      switch_cmd <= 1'b0;
      cfg_wr <= 1'b0;
      cable_present <= 1'b1;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      cfg(1'b1, 3'h4);
      step(2'h2, 2'h0, 3);
      $display("test reset done");
      final_report();
   end
endmodule : rsc_switchover_tb
